/* lra_haptic_drive_config.sv */
// Functional notes
// [R1] idle-ground set: both terminals driven low when idle; clear: both float unless external-bridge is set
// [R2] strict-failure clear: playback always allowed; set: refused while fault pending
// [R3] external-bridge set: logic drive levels on both terminals, else internal bridge
// [R4] software writes drive strength only 0 to 5, typically 5
// [R5] slew code 0..3 selects 20, 40, 80, 160 V/us edge rate
// [R6] slew rate applied only while slew-control enable set, else slew limiting off
// [R7] shoot-through protection active only while its enable bit is set
// [R8] over-temperature protection active only while its enable bit is set
// [R9] over-current protection active only while its enable bit is set
// [R10] autoresonance tracking runs only while its enable bit is set
// [R11] software writes autoresonance backoff only 0 to 100
// [R12] amplitude codes 0..3 give 25, 50, 75, 100 percent drive
// [R13] driven half cycles equal half-cycle field plus one
// [R14] delayed braking waits one half cycle after drive; otherwise brake at once
// [R15] braking phase follows drive only when braking enable is set
// [R16] invert-start set: first half cycle on negative terminal, else positive
// [R17] writing one to trigger starts playback; bit clears itself
// [R18] writing one to stop halts output immediately; bit clears itself
// [R19] over-current sets sticky status flag; reading status clears it
// [R20] enabled protection fault during playback stops drive, pins return idle
`timescale 1ns/1ns
`include "haptic_drive_params.svh"

module lra_haptic_drive_config
    import haptic_drive_pkg::*;
#(
    parameter int HALF_CYCLE_CLKS = `HALF_CYCLE_CLKS
) (
    input  wire logic        REF_CLK,
    input  wire logic        RESET,
    input  wire logic [15:0] REG_ADDR,
    input  wire logic [7:0]  REG_WDATA,
    input  wire logic        REG_WR,
    input  wire logic        REG_RD,
    output logic      [7:0]  REG_RDATA,
    input  wire logic        OCUR_DETECT,
    input  wire logic        OTEMP_DETECT,
    output logic             M_PLUS_OUT,
    output logic             M_PLUS_OE,
    output logic             M_MINUS_OUT,
    output logic             M_MINUS_OE,
    output logic             EXT_BRIDGE,
    output logic [2:0]       DRIVE_STRENGTH,
    output logic [1:0]       SLEW_RATE_SEL,
    output logic             SLEW_LIMIT_EN,
    output logic             SHOOT_PROT_EN,
    output logic             OTEMP_PROT_EN,
    output logic             OCUR_PROT_EN,
    output logic             AUTORES_EN,
    output logic [6:0]       AUTORES_BACKOFF,
    output logic             HAPTICS_ACTIVE
);

    localparam int HC_W = $clog2(HALF_CYCLE_CLKS + 1);

    // ------------------------------------------------------------
    // register file
    // ------------------------------------------------------------
    bridge_output_setup_t     bridge_reg;
    resonance_tracking_ctrl_t reson_reg;
    pulse_shape_descriptor_t  shape_reg;
    logic                     ocur_flag_reg;
    logic                     otemp_flag_reg;
    logic [7:0]               rdata_reg;

    wire wr_lo     = REG_WR && (REG_ADDR == `ADDR_BRIDGE_LO);
    wire wr_hi     = REG_WR && (REG_ADDR == `ADDR_BRIDGE_HI);
    wire wr_reson  = REG_WR && (REG_ADDR == `ADDR_RESONANCE);
    wire wr_shape  = REG_WR && (REG_ADDR == `ADDR_PULSE_SHAPE);
    wire wr_hctl   = REG_WR && (REG_ADDR == `ADDR_HAPTIC_CTRL);
    wire rd_status = REG_RD && (REG_ADDR == `ADDR_SYS_STATUS);

    // control bits are write-only strobes, so they never hold a stored one
    wire trigger_req = wr_hctl && REG_WDATA[`HCTL_TRIGGER_BIT];           // [R17]
    wire stop_req    = wr_hctl && REG_WDATA[`HCTL_STOP_BIT];              // [R18]

    // a fault only counts while its protection is enabled
    wire ocur_fault  = OCUR_DETECT && bridge_reg.ocur_prot_en;            // [R9]
    wire otemp_fault = OTEMP_DETECT && bridge_reg.otemp_prot_en;          // [R8]

    // set wins over the clear-on-read in the same cycle
    wire ocur_flag_next  = ocur_fault || (ocur_flag_reg && !rd_status);   // [R19]
    wire otemp_flag_next = otemp_fault || (otemp_flag_reg && !rd_status);

    logic [7:0] status_byte;
    logic [7:0] rd_mux;
    always_comb begin
        status_byte = 8'h00;
        status_byte[`STAT_OTEMP_BIT]  = otemp_flag_reg;
        status_byte[`STAT_OCUR_BIT]   = ocur_flag_reg;
        status_byte[`STAT_ACTIVE_BIT] = HAPTICS_ACTIVE;
    end

    // reserved bits and unmapped addresses read as zero; control reads zero
    always_comb begin
        unique case (REG_ADDR)
            `ADDR_SYS_STATUS:  rd_mux = status_byte;
            `ADDR_BRIDGE_LO:   rd_mux = bridge_reg[7:0] & 8'h3F;
            `ADDR_BRIDGE_HI:   rd_mux = bridge_reg[15:8] & 8'h3F;
            `ADDR_RESONANCE:   rd_mux = reson_reg;
            `ADDR_PULSE_SHAPE: rd_mux = shape_reg;
            default:           rd_mux = 8'h00;
        endcase
    end

    always_ff @(posedge REF_CLK or posedge RESET) begin
        if (RESET) begin
            bridge_reg     <= `RST_BRIDGE_SETUP;
            reson_reg      <= `RST_RESONANCE;
            shape_reg      <= `RST_PULSE_SHAPE;
            ocur_flag_reg  <= 1'b0;
            otemp_flag_reg <= 1'b0;
            rdata_reg      <= 8'h00;
        end else begin
            if (wr_lo) begin
                bridge_reg[7:0] <= REG_WDATA;
            end
            if (wr_hi) begin
                bridge_reg[15:8] <= REG_WDATA;
            end
            if (wr_reson) begin
                reson_reg <= REG_WDATA;
            end
            if (wr_shape) begin
                shape_reg <= REG_WDATA;
            end
            ocur_flag_reg  <= ocur_flag_next;
            otemp_flag_reg <= otemp_flag_next;
            if (REG_RD) begin
                rdata_reg <= rd_mux;
            end
        end
    end

    // ------------------------------------------------------------
    // playback sequencer
    // ------------------------------------------------------------
    play_state_t      state_reg;
    play_state_t      state_next;
    logic [HC_W-1:0]  hc_cnt_reg;
    logic [2:0]       hc_num_reg;
    logic [1:0]       amp_cnt_reg;
    pulse_shape_descriptor_t shot_reg;

    // strict mode refuses a start while a fault flag is pending
    wire fault_pending = ocur_flag_reg || otemp_flag_reg;
    wire start_ok      = trigger_req && !(bridge_reg.strict_failure && fault_pending); // [R2]
    wire abort         = stop_req || ocur_fault || otemp_fault;           // [R18] [R20]
    wire hc_end        = (hc_cnt_reg == HC_W'(HALF_CYCLE_CLKS - 1));
    wire last_hc       = (hc_num_reg == shot_reg.half_cycles);            // [R13]

    always_comb begin
        state_next = state_reg;
        unique case (state_reg)
            ST_IDLE: begin
                if (start_ok && !abort) begin
                    state_next = ST_DRIVE;                                // [R17]
                end
            end
            ST_DRIVE: begin
                if (hc_end && last_hc) begin
                    if (!shot_reg.brake_enable) begin
                        state_next = ST_IDLE;                             // [R15]
                    end else if (shot_reg.delay_brake) begin
                        state_next = ST_DELAY;                            // [R14]
                    end else begin
                        state_next = ST_BRAKE;                            // [R14]
                    end
                end
            end
            ST_DELAY: begin
                if (hc_end) begin
                    state_next = ST_BRAKE;
                end
            end
            ST_BRAKE: begin
                if (hc_end) begin
                    state_next = ST_IDLE;
                end
            end
        endcase
        if (abort) begin
            state_next = ST_IDLE;                                         // [R18] [R20]
        end
    end

    always_ff @(posedge REF_CLK or posedge RESET) begin
        if (RESET) begin
            state_reg   <= ST_IDLE;
            hc_cnt_reg  <= '0;
            hc_num_reg  <= 3'h0;
            amp_cnt_reg <= 2'h0;
            shot_reg    <= `RST_PULSE_SHAPE;
        end else begin
            state_reg   <= state_next;
            amp_cnt_reg <= amp_cnt_reg + 2'h1;
            if (state_reg == ST_IDLE) begin
                // descriptor is latched at start so a rewrite mid-pulse is harmless
                shot_reg   <= shape_reg;
                hc_cnt_reg <= '0;
                hc_num_reg <= 3'h0;
            end else if (hc_end) begin
                hc_cnt_reg <= '0;
                hc_num_reg <= hc_num_reg + 3'h1;
            end else begin
                hc_cnt_reg <= hc_cnt_reg + HC_W'(1);
            end
        end
    end

    // ------------------------------------------------------------
    // pin drive
    // ------------------------------------------------------------
    // amplitude by chopping: code n drives n+1 of every four cycles
    // pins are registered: work from the coming cycle's shape and half cycle so that
    // the first half cycle starts together with the active flag and lasts a full span
    pulse_shape_descriptor_t shape_now;
    assign shape_now = (state_reg == ST_IDLE) ? shape_reg : shot_reg;
    wire [2:0] hc_now = (state_reg != ST_IDLE && hc_end) ? hc_num_reg + 3'h1 : hc_num_reg;
    wire amp_on   = (amp_cnt_reg <= shape_now.amplitude);                 // [R12]
    wire positive = hc_now[0] ^ shape_now.invert_start;                   // [R16]
    wire driving  = (state_next == ST_DRIVE);

    pin_drive_t plus_next;
    pin_drive_t minus_next;
    always_comb begin
        if (driving) begin
            plus_next  = '{out: !positive && amp_on, oe: 1'b1};
            minus_next = '{out: positive && amp_on, oe: 1'b1};
        end else if (state_next == ST_BRAKE) begin
            plus_next  = '{out: 1'b0, oe: 1'b1};
            minus_next = '{out: 1'b0, oe: 1'b1};
        end else begin
            // external bridge inputs must never float, so they hold a logic low
            plus_next  = '{out: 1'b0,
                           oe: bridge_reg.idle_ground || bridge_reg.external_bridge}; // [R1] [R3]
            minus_next = plus_next;
        end
    end

    always_ff @(posedge REF_CLK or posedge RESET) begin
        if (RESET) begin
            M_PLUS_OUT      <= 1'b0;
            M_PLUS_OE       <= 1'b0;
            M_MINUS_OUT     <= 1'b0;
            M_MINUS_OE      <= 1'b0;
            EXT_BRIDGE      <= 1'b0;
            DRIVE_STRENGTH  <= 3'h0;
            SLEW_RATE_SEL   <= 2'h0;
            SLEW_LIMIT_EN   <= 1'b0;
            SHOOT_PROT_EN   <= 1'b0;
            OTEMP_PROT_EN   <= 1'b0;
            OCUR_PROT_EN    <= 1'b0;
            AUTORES_EN      <= 1'b0;
            AUTORES_BACKOFF <= 7'h00;
            HAPTICS_ACTIVE  <= 1'b0;
        end else begin
            M_PLUS_OUT      <= plus_next.out;
            M_PLUS_OE       <= plus_next.oe;
            M_MINUS_OUT     <= minus_next.out;
            M_MINUS_OE      <= minus_next.oe;
            EXT_BRIDGE      <= bridge_reg.external_bridge;                // [R3]
            DRIVE_STRENGTH  <= bridge_reg.drive_strength;                 // [R4]
            SLEW_RATE_SEL   <= bridge_reg.slew_rate;                      // [R5]
            SLEW_LIMIT_EN   <= bridge_reg.slew_enable;                    // [R6]
            SHOOT_PROT_EN   <= bridge_reg.shoot_prot_en;                  // [R7]
            OTEMP_PROT_EN   <= bridge_reg.otemp_prot_en;                  // [R8]
            OCUR_PROT_EN    <= bridge_reg.ocur_prot_en;                   // [R9]
            AUTORES_EN      <= reson_reg.enable;                          // [R10]
            AUTORES_BACKOFF <= reson_reg.backoff;                         // [R11]
            HAPTICS_ACTIVE  <= (state_next != ST_IDLE);
        end
    end

    assign REG_RDATA = rdata_reg;

endmodule

/* haptic_drive_params.svh */
`ifndef HAPTIC_DRIVE_PARAMS_SVH
`define HAPTIC_DRIVE_PARAMS_SVH

// register byte addresses; the 16-bit bridge setup spans two bytes, low byte first
`define ADDR_SYS_STATUS      16'h1000
`define ADDR_HAPTIC_CTRL     16'h2003
`define ADDR_BRIDGE_LO       16'h3000
`define ADDR_BRIDGE_HI       16'h3001
`define ADDR_RESONANCE       16'h3006
`define ADDR_PULSE_SHAPE     16'h3007

// reset values
`define RST_BRIDGE_SETUP     16'h0000
`define RST_RESONANCE        8'h00
`define RST_PULSE_SHAPE      8'hC0

// haptic control bits
`define HCTL_TRIGGER_BIT     0
`define HCTL_STOP_BIT        1

// status bits
`define STAT_ACTIVE_BIT      1
`define STAT_OCUR_BIT        4
`define STAT_OTEMP_BIT       5

// timing: half cycle of the actuator drive, default for a 170 Hz actuator
`define LRA_FREQ_HZ          170
`define REF_CLK_HZ           125000000
`define HALF_CYCLE_CLKS      (`REF_CLK_HZ / (2 * `LRA_FREQ_HZ))
// amplitude chopping period in clock cycles, four steps of 25 percent
`define AMP_STEPS            4

`endif

/* haptic_drive_pkg.sv */
package haptic_drive_pkg;

    typedef struct packed {
        logic [1:0] rsvd_hi;
        logic       idle_ground;
        logic       strict_failure;
        logic       external_bridge;
        logic [2:0] drive_strength;
        logic [1:0] rsvd_lo;
        logic [1:0] slew_rate;
        logic       slew_enable;
        logic       shoot_prot_en;
        logic       otemp_prot_en;
        logic       ocur_prot_en;
    } bridge_output_setup_t;

    typedef struct packed {
        logic [6:0] backoff;
        logic       enable;
    } resonance_tracking_ctrl_t;

    typedef struct packed {
        logic [1:0] amplitude;
        logic [2:0] half_cycles;
        logic       delay_brake;
        logic       brake_enable;
        logic       invert_start;
    } pulse_shape_descriptor_t;

    typedef struct packed {
        logic out;
        logic oe;
    } pin_drive_t;

    typedef enum logic [1:0] {
        ST_IDLE,
        ST_DRIVE,
        ST_DELAY,
        ST_BRAKE
    } play_state_t;

endpackage

/* lra_haptic_drive_config_monitor.sv */
`timescale 1ns/1ns
module lra_haptic_drive_config_monitor (
    input wire logic        REF_CLK,
    input wire logic        RESET,
    input wire logic [15:0] REG_ADDR,
    input wire logic [7:0]  REG_WDATA,
    input wire logic        REG_WR,
    input wire logic        REG_RD,
    input wire logic [7:0]  REG_RDATA,
    input wire logic        OCUR_DETECT,
    input wire logic        M_PLUS_OUT,
    input wire logic        M_PLUS_OE,
    input wire logic        M_MINUS_OUT,
    input wire logic        M_MINUS_OE,
    input wire logic        EXT_BRIDGE,
    input wire logic [2:0]  DRIVE_STRENGTH,
    input wire logic [1:0]  SLEW_RATE_SEL,
    input wire logic        SLEW_LIMIT_EN,
    input wire logic        SHOOT_PROT_EN,
    input wire logic        OTEMP_PROT_EN,
    input wire logic        OCUR_PROT_EN,
    input wire logic        AUTORES_EN,
    input wire logic [6:0]  AUTORES_BACKOFF,
    input wire logic        HAPTICS_ACTIVE
);
    // ----------------------------------------
    // port checks
    // ----------------------------------------
    default clocking cb @(posedge REF_CLK); endclocking
    default disable iff (RESET);
    wire wr_lo   = REG_WR && REG_ADDR == 16'h3000;
    wire wr_hi   = REG_WR && REG_ADDR == 16'h3001;
    wire wr_res  = REG_WR && REG_ADDR == 16'h3006;
    wire wr_stop = REG_WR && REG_ADDR == 16'h2003 && REG_WDATA[1];
    wire pins_lo = !M_PLUS_OUT && !M_MINUS_OUT;
    property p_lo; wr_lo |=> ##1 {SLEW_RATE_SEL, SLEW_LIMIT_EN, SHOOT_PROT_EN, OTEMP_PROT_EN,
        OCUR_PROT_EN} == $past(REG_WDATA[5:0], 2); endproperty
    a_lo: assert property (p_lo) else $error("bridge low byte copy wrong");
    property p_hi; wr_hi |=> ##1 {EXT_BRIDGE, DRIVE_STRENGTH} == $past(REG_WDATA[3:0], 2);
    endproperty
    a_hi: assert property (p_hi) else $error("bridge high byte copy wrong");
    property p_res; wr_res |=> ##1 {AUTORES_BACKOFF, AUTORES_EN} == $past(REG_WDATA, 2);
    endproperty
    a_res: assert property (p_res) else $error("resonance copy wrong");
    property p_idle; !HAPTICS_ACTIVE |-> pins_lo && M_PLUS_OE == M_MINUS_OE; endproperty
    a_idle: assert property (p_idle) else $error("idle pins differ");
    property p_ext; !HAPTICS_ACTIVE && EXT_BRIDGE |-> M_PLUS_OE && M_MINUS_OE; endproperty
    a_ext: assert property (p_ext) else $error("external idle not driven");
    property p_stop; wr_stop |=> !HAPTICS_ACTIVE && pins_lo; endproperty
    a_stop: assert property (p_stop) else $error("stop did not halt");
    // the enable copy lags the register by one cycle, so skip the cycle after a rewrite
    property p_fault; HAPTICS_ACTIVE && OCUR_DETECT && OCUR_PROT_EN && !$past(wr_lo)
        |=> !HAPTICS_ACTIVE; endproperty
    a_fault: assert property (p_fault) else $error("fault did not abort");
    property p_ctl; REG_RD && REG_ADDR == 16'h2003 |=> REG_RDATA == 8'h00; endproperty
    a_ctl: assert property (p_ctl) else $error("control byte not self clearing");
    property p_flag; OCUR_DETECT && OCUR_PROT_EN && !$past(wr_lo)
        ##1 REG_RD && REG_ADDR == 16'h1000 |=> REG_RDATA[4]; endproperty
    a_flag: assert property (p_flag) else $error("over-current flag missing");
endmodule
bind lra_haptic_drive_config lra_haptic_drive_config_monitor mon (.REF_CLK(REF_CLK),
    .RESET(RESET), .REG_ADDR(REG_ADDR), .REG_WDATA(REG_WDATA), .REG_WR(REG_WR),
    .REG_RD(REG_RD), .REG_RDATA(REG_RDATA), .OCUR_DETECT(OCUR_DETECT), .M_PLUS_OUT(M_PLUS_OUT),
    .M_PLUS_OE(M_PLUS_OE), .M_MINUS_OUT(M_MINUS_OUT), .M_MINUS_OE(M_MINUS_OE),
    .EXT_BRIDGE(EXT_BRIDGE), .DRIVE_STRENGTH(DRIVE_STRENGTH), .SLEW_RATE_SEL(SLEW_RATE_SEL),
    .SLEW_LIMIT_EN(SLEW_LIMIT_EN), .SHOOT_PROT_EN(SHOOT_PROT_EN),
    .OTEMP_PROT_EN(OTEMP_PROT_EN), .OCUR_PROT_EN(OCUR_PROT_EN), .AUTORES_EN(AUTORES_EN),
    .AUTORES_BACKOFF(AUTORES_BACKOFF), .HAPTICS_ACTIVE(HAPTICS_ACTIVE));

/* lra_actuator_model.sv */
`timescale 1ns/1ns
module lra_actuator_model (
    input wire logic [1:0] fault_cmd,
    output logic           ocur,
    output logic           otemp
);
    // ----------------------------------------
    // fault sensing
    // ----------------------------------------
    // healthy coil: detectors fire only when the bench commands a fault
    assign ocur  = fault_cmd[0];
    assign otemp = fault_cmd[1];
endmodule

/* lra_haptic_drive_config_tb_top.sv */
`timescale 1ns/1ns
`define CHK(nm, ex, got) begin check_count++; if ((got) !== (ex)) begin err_count++; \
    $display("BAD %s exp %0h got %0h", nm, ex, got); end end
module lra_haptic_drive_config_tb_top;
    import haptic_drive_pkg::*;
    // ----------------------------------------
    // harness
    // ----------------------------------------
    localparam int H = 8;
    int          err_count = 0;
    int          check_count = 0;
    logic        clk = 0;
    logic        rst = 1;
    logic        wr = 0;
    logic        rd = 0;
    logic [1:0]  flt = '0;
    logic [15:0] addr = '0;
    logic [7:0]  wd = '0;
    logic [7:0]  rdat;
    logic        mp, mpe, mn, mne, act, oc, ot;
    lra_haptic_drive_config #(.HALF_CYCLE_CLKS(H)) dut (.REF_CLK(clk), .RESET(rst),
        .REG_ADDR(addr), .REG_WDATA(wd), .REG_WR(wr), .REG_RD(rd), .REG_RDATA(rdat),
        .OCUR_DETECT(oc), .OTEMP_DETECT(ot), .M_PLUS_OUT(mp), .M_PLUS_OE(mpe),
        .M_MINUS_OUT(mn), .M_MINUS_OE(mne), .EXT_BRIDGE(), .DRIVE_STRENGTH(),
        .SLEW_RATE_SEL(), .SLEW_LIMIT_EN(), .SHOOT_PROT_EN(), .OTEMP_PROT_EN(),
        .OCUR_PROT_EN(), .AUTORES_EN(), .AUTORES_BACKOFF(), .HAPTICS_ACTIVE(act));
    lra_actuator_model coil (.fault_cmd(flt), .ocur(oc), .otemp(ot));
    always #4 clk = ~clk;
    task automatic wr8(input logic [15:0] a, input logic [7:0] d);
        @(negedge clk);
        addr = a;
        wd = d;
        wr = 1;
        @(negedge clk);
        wr = 0;
    endtask
    task automatic rd8(input logic [15:0] a, output logic [7:0] d);
        @(negedge clk);
        addr = a;
        rd = 1;
        @(negedge clk);
        rd = 0;
        d = rdat;
    endtask
    task automatic wrrd(input logic [15:0] a, input logic [7:0] v, input logic [7:0] m);
        logic [7:0] d;
        wr8(a, v);
        rd8(a, d);
        `CHK("readback", v & m, d);
    endtask
    task automatic fault(input logic [1:0] f);
        @(negedge clk);
        flt = f;
        @(negedge clk);
        flt = '0;
    endtask
    function automatic int exp_len(input logic [7:0] s);
        return (s[5:3] + 1 + (s[1] ? 1 + s[2] : 0)) * H;
    endfunction
    // chopped level: amplitude code n gives n+1 high clocks in every 4
    task automatic play(input logic [7:0] s, input logic g);
        int n = 0;
        int hi = 0;
        int f0 = 0;
        int f1 = 0;
        int ch;
        ch = (s[7:6] + 1) * H / 4;
        wr8(16'h3001, {2'b00, g, 5'b00101});
        wr8(16'h3007, s);
        // first active cycle is the one in which the trigger write returns
        wr8(16'h2003, 8'h01);
        while (act === 1'b1 && n < 200) begin
            if (n < H) begin
                f0 += mp;
                f1 += mn;
            end
            hi += mp + mn;
            n++;
            @(negedge clk);
        end
        `CHK("length", exp_len(s), n);
        `CHK("chop", (s[5:3] + 1) * ch, hi);
        `CHK("lead", ch, s[0] ? f1 : f0);
        `CHK("lag", 0, s[0] ? f0 : f1);
        `CHK("idle oe", g, mpe);
    endtask
    task automatic report_and_stop;
        $display("checks %0d mismatches %0d", check_count, err_count);
        if (err_count == 0 && check_count > 0) $display("Run complete: PASS");
        else $display("Run complete: FAIL");
        $finish;
    endtask
    initial begin
        #100000;
        err_count++;
        $display("watchdog expired");
        report_and_stop();
    end
    // ----------------------------------------
    // tests
    // ----------------------------------------
    initial begin
        logic [7:0]  d;
        logic [15:0] ra [5] = '{16'h3000, 16'h3001, 16'h3006, 16'h3007, 16'h4000};
        logic [7:0]  rv [5] = '{8'h00, 8'h00, 8'h00, 8'hC0, 8'h00};
        logic [7:0]  sh [5] = '{8'h00, 8'hFF, 8'hC6, 8'h7B, 8'h3A};
        void'($urandom(32'hD74A2C41));
        repeat (4) @(posedge clk);
        @(negedge clk);
        rst = 0;
        foreach (ra[i]) begin
            rd8(ra[i], d);
            `CHK("reset value", rv[i], d);
        end
        repeat (4) begin
            wrrd(16'h3000, 8'($urandom), 8'h3F);
            wrrd(16'h3001, {5'b11000, 3'($urandom % 6)}, 8'h3F);
            wrrd(16'h3006, {7'($urandom % 101), 1'($urandom)}, 8'hFF);
        end
        wrrd(16'h5555, 8'hFF, 8'h00);
        $display("test registers done");
        wr8(16'h3000, 8'h07);
        foreach (sh[i]) play(sh[i], i[0]);
        repeat (4) play(8'($urandom), 1'($urandom));
        $display("test playback done");
        wr8(16'h3007, 8'hF8);
        wr8(16'h2003, 8'h01);
        repeat (5) @(negedge clk);
        `CHK("playing", 1'b1, act);
        wr8(16'h2003, 8'h02);
        @(negedge clk);
        `CHK("stop", 1'b0, act);
        rd8(16'h2003, d);
        `CHK("control byte", 8'h00, d);
        wr8(16'h3000, 8'h00);
        wr8(16'h2003, 8'h01);
        fault(2'b01);
        @(negedge clk);
        `CHK("unprotected", 1'b1, act);
        wr8(16'h3000, 8'h03);
        fault(2'b01);
        @(negedge clk);
        `CHK("abort", 1'b0, act);
        rd8(16'h1000, d);
        `CHK("ocur flag", 1'b1, d[4]);
        rd8(16'h1000, d);
        `CHK("flag cleared", 1'b0, d[4]);
        // fault still present at the clearing read: the set must win
        @(negedge clk);
        flt = 2'b01;
        rd8(16'h1000, d);
        flt = 2'b00;
        `CHK("set wins", 1'b1, d[4]);
        rd8(16'h1000, d);
        `CHK("flag kept", 1'b1, d[4]);
        rd8(16'h1000, d);
        `CHK("flag gone", 1'b0, d[4]);
        wr8(16'h3001, 8'h15);
        fault(2'b10);
        wr8(16'h2003, 8'h01);
        @(negedge clk);
        `CHK("strict refuse", 1'b0, act);
        rd8(16'h1000, d);
        wr8(16'h2003, 8'h01);
        @(negedge clk);
        `CHK("strict allow", 1'b1, act);
        wr8(16'h2003, 8'h02);
        wr8(16'h3001, 8'h0D);
        repeat (2) @(negedge clk);
        `CHK("ext idle oe", 2'b11, {mpe, mne});
        `CHK("ext idle out", 2'b00, {mp, mn});
        $display("test protection done");
        report_and_stop();
    end
endmodule
